// ==== rtl/apms_device.sv ====
// converter end: mode sequencing and serial framing
`timescale 1ns/1ns
module apms_device (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  apms_link_if.dev link,
  input wire logic [11:0] i_result_first,
  input wire logic [11:0] i_result_second,
  output logic o_sample,
  output logic [1:0] o_mode,
  output logic o_analog_on,
  output logic o_ref_on,
  output logic o_frame_active
);
  // ========================================================================
  // input edges
  logic cs_n_d_r;
  logic sclk_d_r;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  assign cs_fall = cs_n_d_r & ~link.cs_n;
  assign cs_rise = ~cs_n_d_r & link.cs_n;
  assign sclk_fall = sclk_d_r & ~link.sclk;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_n_d_r <= 1'b1;
      sclk_d_r <= 1'b0;
    end else begin
      cs_n_d_r <= link.cs_n;
      sclk_d_r <= link.sclk;
    end
  end

  // ========================================================================
  // falling edge counter
  logic [5:0] edge_cnt_r;
  logic frame_r;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      edge_cnt_r <= 6'h00;
    end else if (cs_fall) begin
      edge_cnt_r <= 6'h00; // [RQ22] [RQ23]
    end else if (frame_r && sclk_fall && edge_cnt_r != 6'h3F) begin
      edge_cnt_r <= edge_cnt_r + 6'h01;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      frame_r <= 1'b0;
    end else if (cs_fall) begin
      frame_r <= 1'b1;
    end else if (link.cs_n) begin
      frame_r <= 1'b0;
    end
  end

  // ========================================================================
  // mode state
  apms_pkg::apms_mode_t mode_r;
  apms_pkg::apms_mode_t mode_nxt;
  always_comb begin
    mode_nxt = mode_r;
    if (frame_r && cs_rise) begin
      if (edge_cnt_r >= apms_pkg::EDGE_KEEP) begin
        mode_nxt = apms_pkg::PM_NORMAL; // [RQ3] [RQ14]
      end else if (edge_cnt_r >= apms_pkg::EDGE_GLITCH) begin
        unique case (mode_r)
          apms_pkg::PM_NORMAL: mode_nxt = apms_pkg::PM_PARTIAL; // [RQ11]
          default: mode_nxt = apms_pkg::PM_FULL; // [RQ16]
        endcase
      end else begin
        mode_nxt = mode_r; // [RQ12] [RQ15]
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_r <= apms_pkg::PM_NORMAL;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  // power-up starts on select fall, dropped again on early rise
  logic waking;
  assign waking = frame_r && mode_r != apms_pkg::PM_NORMAL;
  assign o_mode = mode_r;
  assign o_analog_on = mode_r == apms_pkg::PM_NORMAL || waking; // [RQ13] [RQ18]
  assign o_ref_on = mode_r != apms_pkg::PM_FULL || waking; // [RQ13] [RQ18]
  assign o_frame_active = frame_r;

  // ========================================================================
  // sample capture and shift
  logic [11:0] hold_first_r;
  logic [11:0] hold_second_r;
  logic sample_r;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hold_first_r <= 12'h000;
      hold_second_r <= 12'h000;
      sample_r <= 1'b0;
    end else begin
      sample_r <= cs_fall; // [RQ1]
      if (cs_fall) begin
        hold_first_r <= i_result_first; // [RQ1]
        hold_second_r <= i_result_second;
      end
    end
  end
  assign o_sample = sample_r;

  // bit for a given count: two leading zeros, 12 data, zeros, other result
  function automatic logic frame_bit(input logic [5:0] cnt, input logic [11:0] own, input logic [11:0] other);
    logic [5:0] pos;
    pos = (cnt >= apms_pkg::EDGE_PAD) ? cnt - apms_pkg::EDGE_PAD : cnt;
    if (pos < 6'h02 || pos >= apms_pkg::EDGE_RESULT) begin
      frame_bit = 1'b0; // [RQ6]
    end else begin
      frame_bit = (cnt >= apms_pkg::EDGE_PAD) ? other[4'hD - pos[3:0]] : own[4'hD - pos[3:0]]; // [RQ4] [RQ7]
    end
  endfunction

  logic dout_a_r;
  logic dout_b_r;
  logic drive_r;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dout_a_r <= 1'b0;
      dout_b_r <= 1'b0;
    end else if (cs_fall) begin
      dout_a_r <= 1'b0;
      dout_b_r <= 1'b0;
    end else if (frame_r && sclk_fall) begin
      dout_a_r <= frame_bit(edge_cnt_r + 6'h01, hold_first_r, hold_second_r);
      dout_b_r <= frame_bit(edge_cnt_r + 6'h01, hold_second_r, hold_first_r);
    end
  end

  // ========================================================================
  // output drive window
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      drive_r <= 1'b0;
    end else if (cs_fall) begin
      drive_r <= 1'b1;
    end else if (link.cs_n) begin
      drive_r <= 1'b0; // [RQ3] [RQ5] [RQ11]
    end else if (frame_r && sclk_fall && edge_cnt_r == apms_pkg::EDGE_DUAL - 6'h01) begin
      drive_r <= 1'b0; // [RQ8]
    end
  end

  assign link.dout_first = dout_a_r;
  assign link.dout_second = dout_b_r;
  assign link.dout_first_oe_n = ~drive_r;
  assign link.dout_second_oe_n = ~drive_r;
endmodule

// ==== rtl/apms_host.sv ====
// host end: frame generator and result capture
`timescale 1ns/1ns
module apms_host (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  apms_link_if.host link,
  input wire logic i_start,
  input wire logic [15:0] i_frame_len,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_word_first,
  output logic [15:0] o_word_second
);
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_RUN = 2'b01,
    HS_QUIET = 2'b10
  } apms_hstate_t;

  // ========================================================================
  apms_hstate_t st_r;
  logic [15:0] len_r;
  logic [15:0] edges_r;
  logic [3:0] div_r;
  logic sclk_r;
  logic [15:0] quiet_r;
  logic [15:0] sh_a_r;
  logic [15:0] sh_b_r;
  logic done_r;

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= HS_IDLE;
      len_r <= 16'h0000;
      edges_r <= 16'h0000;
      div_r <= 4'h0;
      sclk_r <= 1'b1;
      quiet_r <= 16'h0000;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (st_r)
        HS_IDLE: begin
          if (i_start) begin
            st_r <= HS_RUN; // [RQ21]
            len_r <= (i_frame_len == 16'h0000) ? apms_pkg::FRAME_LEN_SHORT : i_frame_len; // [RQ2] [RQ4] [RQ17]
            edges_r <= 16'h0000;
            div_r <= 4'h0;
            sclk_r <= 1'b1;
          end
        end
        HS_RUN: begin
          if (div_r == apms_pkg::SCLK_HALF - 4'h1) begin
            div_r <= 4'h0;
            if (sclk_r && edges_r == len_r) begin
              st_r <= HS_QUIET; // [RQ9]
              quiet_r <= 16'(apms_pkg::QUIET_CYC);
            end else begin
              sclk_r <= ~sclk_r;
              if (sclk_r) begin
                edges_r <= edges_r + 16'h0001;
              end
            end
          end else begin
            div_r <= div_r + 4'h1;
          end
        end
        HS_QUIET: begin
          if (quiet_r == 16'h0000) begin
            st_r <= HS_IDLE; // [RQ10]
            done_r <= 1'b1;
          end else begin
            quiet_r <= quiet_r - 16'h0001;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  // ========================================================================
  // capture on rising sclk edges while selected
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sh_a_r <= 16'h0000;
      sh_b_r <= 16'h0000;
    end else if (st_r == HS_IDLE && i_start) begin
      sh_a_r <= 16'h0000;
      sh_b_r <= 16'h0000;
    end else if (st_r == HS_RUN && div_r == apms_pkg::SCLK_HALF - 4'h1 && !sclk_r) begin
      sh_a_r <= {sh_a_r[14:0], link.dout_first};
      sh_b_r <= {sh_b_r[14:0], link.dout_second};
    end
  end

  assign link.cs_n = st_r != HS_RUN;
  assign link.sclk = sclk_r;
  assign o_busy = st_r != HS_IDLE;
  assign o_done = done_r;
  assign o_word_first = sh_a_r;
  assign o_word_second = sh_b_r;
endmodule

// ==== rtl/apms_link_if.sv ====
// serial link between host controller and converter
`timescale 1ns/1ns
interface apms_link_if;
  logic cs_n;
  logic sclk;
  logic dout_first;
  logic dout_first_oe_n;
  logic dout_second;
  logic dout_second_oe_n;
  modport dev (
    input cs_n,
    input sclk,
    output dout_first,
    output dout_first_oe_n,
    output dout_second,
    output dout_second_oe_n
  );
  modport host (
    output cs_n,
    output sclk,
    input dout_first,
    input dout_first_oe_n,
    input dout_second,
    input dout_second_oe_n
  );
endinterface

// ==== rtl/apms_pkg.sv ====
// constants and types shared by both ends of the power mode sequencer link
// ==========================================================================
// Functional notes
// [RQ1] chip-select fall samples and starts conversion
// [RQ2] host holds select through ten falling edges
// [RQ3] rise between edges 10-14 aborts, stays powered
// [RQ4] one result takes fourteen serial clocks
// [RQ5] after fourteen, output drives until select rises
// [RQ6] two more clocks give two trailing zeros
// [RQ7] further 14/16 clocks give other result
// [RQ8] output releases at edge 32 or rise
// [RQ9] host may idle select low after 32
// [RQ10] host waits quiet and acquisition before next
// [RQ11] normal, rise in edges 2-9: partial sleep
// [RQ12] normal, rise before edge 2: stay normal
// [RQ13] partial sleep keeps only reference powered
// [RQ14] dummy conversion past ten wakes partial sleep
// [RQ15] partial, rise before edge 2: stay partial
// [RQ16] partial, rise in edges 2-9: full sleep
// [RQ17] host may skip remaining frame clocks
// [RQ18] full sleep powers everything down
// [RQ19] full sleep wake: dummy then 1.5 ms
// [RQ20] partial sleep 67 us before short wake
// [RQ21] host initialises with dummy cycles after power-on; the host sends no dummy cycles and starts frames only on i_start
// [RQ22] edge counter clears on each select fall
// [RQ23] coincident falling edge not counted
package apms_pkg;
  // ========================================================================
  // frame edge positions
  localparam logic [5:0] EDGE_GLITCH = 6'h02;
  localparam logic [5:0] EDGE_KEEP = 6'h0A;
  localparam logic [5:0] EDGE_RESULT = 6'h0E;
  localparam logic [5:0] EDGE_PAD = 6'h10;
  localparam logic [5:0] EDGE_DUAL = 6'h20;
  localparam int RESULT_BITS = 12;
  localparam logic [15:0] FRAME_LEN_SHORT = 16'h000E;
  localparam logic [15:0] FRAME_LEN_LONG = 16'h0010;
  localparam logic [15:0] FRAME_LEN_DUAL = 16'h0020;
  localparam logic [15:0] FRAME_LEN_SLEEP = 16'h0004;
  // ========================================================================
  // timing, clock 100 MHz
  localparam int CLK_PERIOD_NS = 10;
  localparam int PARTIAL_WAKE_NS = 1000;
  localparam int DEEP_SLEEP_WAKE_TIME_US = 1500;
  localparam int PARTIAL_DWELL_US = 67;
  localparam int BUS_QUIET_INTERVAL_NS = 60;
  localparam int PARTIAL_WAKE_CYC = (PARTIAL_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEEP_WAKE_CYC = (DEEP_SLEEP_WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PARTIAL_DWELL_CYC = (PARTIAL_DWELL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int QUIET_CYC = (BUS_QUIET_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCLK_HALF = 4'h2;
  // ========================================================================
  typedef enum logic [1:0] {
    PM_NORMAL = 2'b00,
    PM_PARTIAL = 2'b01,
    PM_FULL = 2'b10
  } apms_mode_t;
endpackage

// ==== tb/adc_power_mode_sequencer_tb.sv ====
// self-checking bench joining host and converter ends
`timescale 1ns/1ns
module adc_power_mode_sequencer_tb;
  logic clk, rstn, start, samp, ana, ref_on, done;
  logic [15:0] len, word_a, word_b;
  logic [11:0] res_a, res_b;
  logic [1:0] mode;
  int n_fail, tests_run, n_samp, n_frm;
  apms_link_if link ();
  apms_device i_apms_device (.i_core_clk(clk), .i_rstn(rstn), .link(link), .i_result_first(res_a),
    .i_result_second(res_b), .o_sample(samp), .o_mode(mode), .o_analog_on(ana), .o_ref_on(ref_on),
    .o_frame_active());
  apms_host i_apms_host (.i_core_clk(clk), .i_rstn(rstn), .link(link), .i_start(start), .i_frame_len(len),
    .o_busy(), .o_done(done), .o_word_first(word_a), .o_word_second(word_b));
  apms_chk i_apms_chk (.i_core_clk(clk), .i_rstn(rstn), .cs_n(link.cs_n), .sclk(link.sclk),
    .dout_first(link.dout_first), .dout_first_oe_n(link.dout_first_oe_n), .dout_second(link.dout_second),
    .dout_second_oe_n(link.dout_second_oe_n));
  // ====
  // shared tasks
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic frame(input logic [15:0] n);
    int k;
    @(negedge clk);
    len = n;
    start = 1'b1;
    n_frm++;
    @(negedge clk);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
    if (k == 2000) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic expect_mode(input logic [1:0] m);
    check("mode", {14'h0000, mode}, {14'h0000, m});
    check("analog", {15'h0000, ana}, {15'h0000, m == apms_pkg::PM_NORMAL});
    check("ref", {15'h0000, ref_on}, {15'h0000, m != apms_pkg::PM_FULL});
  endtask
  // ====
  // scenarios
  task automatic t_read();
    res_a = 12'hA5C;
    res_b = 12'h3E1;
    frame(16'h0010);
    // host samples on rising edges, so the lead zero shown at select fall is not captured
    check("word_a", word_a, {1'b0, res_a, 3'b000});
    check("word_b", word_b, {1'b0, res_b, 3'b000});
    frame(16'h0020);
    check("dual_a", word_a, {1'b0, res_b, 3'b000});
    check("dual_b", word_b, {1'b0, res_a, 3'b000});
    expect_mode(apms_pkg::PM_NORMAL);
    $display("t_read done");
  endtask
  task automatic t_modes();
    logic [15:0] lens [8] = '{16'h1, 16'h2, 16'h1, 16'h9, 16'hA, 16'h5, 16'hC, 16'hC};
    logic [1:0] exp [8] = '{2'b00, 2'b01, 2'b01, 2'b10, 2'b00, 2'b01, 2'b00, 2'b00};
    for (int i = 0; i < 8; i++) begin
      frame(lens[i]);
      expect_mode(exp[i]);
    end
    frame(16'h0002);
    expect_mode(apms_pkg::PM_PARTIAL);
    repeat (apms_pkg::PARTIAL_DWELL_CYC) @(negedge clk);
    frame(16'h000A);
    expect_mode(apms_pkg::PM_NORMAL);
    $display("t_modes done");
  endtask
  task automatic t_reset();
    frame(16'h0003);
    expect_mode(apms_pkg::PM_PARTIAL);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    expect_mode(apms_pkg::PM_NORMAL);
    res_a = 12'hFFF;
    frame(16'h0010);
    check("after_rst", word_a, {1'b0, res_a, 3'b000});
    $display("t_reset done");
  endtask
  // ====
  // clock, sample monitor, main sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (samp === 1'b1) begin
      n_samp++;
    end
  end
  initial begin
    rstn = 1'b0;
    start = 1'b0;
    len = 16'h0000;
    res_a = 12'h000;
    res_b = 12'h000;
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    t_read();
    t_modes();
    t_reset();
    check("samples", n_samp[15:0], n_frm[15:0]);
    conclude();
  end
endmodule

// ==== tb/apms_chk.sv ====
// concurrent checks on the serial link
`timescale 1ns/1ns
module apms_chk (
  input wire logic i_core_clk,
  input wire logic i_rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic dout_first,
  input wire logic dout_first_oe_n,
  input wire logic dout_second,
  input wire logic dout_second_oe_n
);
  // ====
  // serial clock falls counted in a frame
  logic cs_q_r;
  logic sclk_q_r;
  logic [5:0] cnt_r;
  logic in_frame;
  logic off;
  logic on;
  logic zero;
  assign in_frame = !cs_n && !cs_q_r;
  assign off = dout_first_oe_n && dout_second_oe_n;
  assign on = !dout_first_oe_n && !dout_second_oe_n;
  assign zero = !dout_first && !dout_second;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_q_r <= 1'b1;
      sclk_q_r <= 1'b1;
    end else begin
      cs_q_r <= cs_n;
      sclk_q_r <= sclk;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= 6'h00;
    end else if (cs_q_r && !cs_n) begin
      cnt_r <= 6'h00;
    end else if (in_frame && sclk_q_r && !sclk && cnt_r != 6'h3F) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end
  // ====
  // assertions
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rstn);
  chk_select_drive: assert property ($fell(cs_n) |-> ##[1:2] on)
    else $error("lines not driven");
  chk_rise_release: assert property ($rose(cs_n) |-> ##[1:2] off)
    else $error("lines not released");
  chk_end_release: assert property (in_frame && cnt_r == 6'h20 |-> ##[0:2] off)
    else $error("no release at 32");
  chk_drive_hold: assert property (in_frame && cnt_r inside {[6'h0E:6'h1E]} |-> on)
    else $error("released early");
  chk_lead_zero: assert property (in_frame && cnt_r < 6'h02 && on |-> zero)
    else $error("leading zero bad");
  chk_trail_zero: assert property (in_frame && cnt_r inside {6'h0F, 6'h1F} && on |-> zero)
    else $error("trailing zero bad");
  chk_second_lead: assert property (in_frame && cnt_r inside {6'h10, 6'h11} && on |-> zero)
    else $error("second lead bad");
  chk_idle_off: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> off)
    else $error("driven while idle");
  chk_quiet_gap: assert property ($rose(cs_n) |-> cs_n [*6])
    else $error("quiet gap short");
endmodule
